// ### core/dss_top.sv
// Purpose: basic-setup settings and communication watchdog of a drive
// Assumes: synchronous high reset clears errors; inputs synchronous
// Notes: one always_comb builds next state, one always_ff stores it
// Function
// - code 0 ignores missing phase, runs on two phases, caps peak 4 A.
// - code 1 warns on missing phase, stays enabled, caps peak 4 A.
// - code 2 faults on missing phase, disables, opens ready contact.
// - operating time counted and committed to storage every 8 minutes.
// - station address 1 to 63, default 0.
// - fieldbus address used when set, else station address.
// - can bit rate from eleven listed rates, default 500 kbps.
// - eight character name, blanks by default.
// - auto enable sets software enable at reset in modes 0,2,4-8.
// - watchdog runs when timeout nonzero and output stage enabled.
// - missing retrigger raises timeout warning, stops drive, stays enabled.
// - after timeout, setpoints rejected until reset.
// - acceleration unit codes 0 to 5, default 0.
// - acceleration unit change converts parameters, not motion blocks.
// - velocity unit codes 0 to 8, default 0.
// - speed parameters are 32-bit fixed point, three decimals.
// - velocity parameters are 32-bit integers.
// - position unit codes 0 to 9, default 0.
// - hardware, firmware versions and serial readable only.
//
// Local design decisions: the APB slave port and the address map.
module dss_top
  import dss_pkg::*;
#(
  parameter int unsigned SAVE_PERIOD_MS = SAVE_MS,
  parameter int unsigned TICK_CYCLES = CYC_PER_MS,
  parameter logic [31:0] HW_VERSION = 32'h0000_0001, // arbitrary
  parameter logic [31:0] FW_VERSION = 32'h0000_0001, // arbitrary
  parameter logic [31:0] SERIAL_NUM = 32'h0000_1234 // arbitrary
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire dss_pkg::dss_apb_req_t apb_req,
  output dss_pkg::dss_apb_rsp_t apb_rsp,
  input wire logic phase_missing,
  input wire logic output_stage_enabled,
  input wire logic [3:0] operating_function,
  input wire logic bus_retrigger,
  input wire logic setpoint_valid,
  input wire logic [31:0] setpoint_in,
  input wire logic accel_convert_done,
  output logic setpoint_accept,
  output logic [31:0] setpoint_out,
  output dss_pkg::dss_drive_t drive,
  output logic [5:0] bus_node_id,
  output logic [3:0] can_bit_rate,
  output logic [3:0] accel_unit_select,
  output logic [3:0] velocity_unit_select,
  output logic [3:0] position_unit,
  output logic accel_convert_req,
  output logic nv_commit,
  output logic [31:0] operating_time
);
  typedef struct packed {
    logic [1:0] phase_loss_handling;
    logic [5:0] station_addr;
    logic [5:0] bus_addr;
    logic [3:0] can_bit_rate;
    logic [63:0] axis_label;
    logic auto_software_enable;
    logic sw_enable;
    logic [15:0] comm_watchdog_timeout;
    logic [15:0] wd_count;
    logic response_timeout_warning;
    logic [3:0] accel_unit_select;
    logic [3:0] velocity_unit_select;
    logic [3:0] position_unit;
    logic accel_convert_req;
    logic [31:0] tick_count;
    logic [31:0] ms_count;
    logic [31:0] operating_time;
    logic [31:0] saved_time;
    logic nv_commit;
    dss_drive_t drive;
    logic [5:0] bus_node_id;
    logic setpoint_accept;
    logic [31:0] setpoint_out;
    dss_apb_rsp_t rsp;
  } dss_state_t;

  dss_state_t state_reg;
  dss_state_t state_next;
  logic tick;
  logic wr;
  logic rd;
  logic enable_mode;
  logic wd_active;
  logic rst_seen_reg;

  assign tick = (state_reg.tick_count == 32'(TICK_CYCLES - 1));
  // answer once: the held second access cycle must not write again
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite &&
    !state_reg.rsp.pready;
  assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite &&
    !state_reg.rsp.pready;
  // modes 1, 3 take their enable elsewhere
  assign enable_mode = (operating_function == 4'h0) ||
    (operating_function == 4'h2) ||
    ((operating_function >= 4'h4) && (operating_function <= 4'h8));
  assign wd_active = (state_reg.comm_watchdog_timeout != 16'h0000) &&
    output_stage_enabled;

  always_comb begin
    state_next = state_reg;
    state_next.nv_commit = 1'b0;
    state_next.accel_convert_req = state_reg.accel_convert_req &&
      !accel_convert_done;
    state_next.rsp.pready = 1'b0;
    state_next.rsp.pslverr = 1'b0;
    state_next.tick_count = tick ? 32'h0000_0000 :
      state_reg.tick_count + 32'h0000_0001;

    // run time: committed copy only advances on the save period
    if (tick) begin
      state_next.ms_count = state_reg.ms_count + 32'h0000_0001;
      if (state_reg.ms_count == 32'(SAVE_PERIOD_MS - 1)) begin
        state_next.ms_count = 32'h0000_0000;
        state_next.operating_time = state_reg.operating_time +
          32'h0000_0001;
        state_next.saved_time = state_next.operating_time;
        state_next.nv_commit = 1'b1;
      end
    end

    // watchdog
    if (bus_retrigger) begin
      state_next.wd_count = state_reg.comm_watchdog_timeout;
    end else if (!wd_active) begin
      state_next.wd_count = state_reg.comm_watchdog_timeout;
    end else if (tick) begin
      if (state_reg.wd_count <= 16'h0001) begin
        state_next.wd_count = 16'h0000;
        state_next.response_timeout_warning = 1'b1;
      end else begin
        state_next.wd_count = state_reg.wd_count - 16'h0001;
      end
    end

    // apb: pready one cycle after the access phase opens
    state_next.rsp.prdata = 32'h0000_0000;
    if (wr || rd) begin
      state_next.rsp.pready = 1'b1;
    end
    if (wr) begin
      unique case (apb_req.paddr)
        A_PHASE: begin
          // host keeps to disabled and reset; illegal code 3 refused
          if (apb_req.pwdata[1:0] != 2'h3) begin
            state_next.phase_loss_handling = apb_req.pwdata[1:0];
          end else begin
            state_next.rsp.pslverr = 1'b1;
          end
        end
        A_ADDR: begin
          state_next.station_addr = apb_req.pwdata[5:0];
          state_next.bus_addr = apb_req.pwdata[13:8];
        end
        A_CANBR: begin
          if (apb_req.pwdata[3:0] <= CANBR_MAX) begin
            state_next.can_bit_rate = apb_req.pwdata[3:0];
          end else begin
            state_next.rsp.pslverr = 1'b1;
          end
        end
        A_LABEL0: state_next.axis_label[31:0] = apb_req.pwdata;
        A_LABEL1: state_next.axis_label[63:32] = apb_req.pwdata;
        A_AUTOEN: state_next.auto_software_enable = apb_req.pwdata[0];
        A_CTRL: state_next.sw_enable = apb_req.pwdata[0];
        A_WDTO: begin
          state_next.comm_watchdog_timeout = apb_req.pwdata[15:0];
          state_next.wd_count = apb_req.pwdata[15:0];
        end
        A_UNITS: begin
          if ((apb_req.pwdata[3:0] > ACC_MAX) ||
              (apb_req.pwdata[11:8] > VEL_MAX) ||
              (apb_req.pwdata[19:16] > POS_MAX)) begin
            state_next.rsp.pslverr = 1'b1;
          end else begin
            state_next.accel_unit_select = apb_req.pwdata[3:0];
            state_next.velocity_unit_select = apb_req.pwdata[11:8];
            state_next.position_unit = apb_req.pwdata[19:16];
            // motion blocks are not in the converted set
            if (apb_req.pwdata[3:0] != state_reg.accel_unit_select) begin
              state_next.accel_convert_req = 1'b1;
            end
          end
        end
        A_KICK: state_next.wd_count = state_reg.comm_watchdog_timeout;
        default: state_next.rsp.pslverr = 1'b1; // read-only or unmapped
      endcase
    end
    if (rd) begin
      unique case (apb_req.paddr)
        A_CTRL: state_next.rsp.prdata = {31'h0, state_reg.sw_enable};
        A_STATUS: state_next.rsp.prdata = {24'h0, state_reg.drive};
        A_PHASE: state_next.rsp.prdata = {30'h0,
          state_reg.phase_loss_handling};
        A_ADDR: state_next.rsp.prdata = {10'h0, state_reg.bus_node_id,
          2'h0, state_reg.bus_addr, 2'h0, state_reg.station_addr};
        A_CANBR: state_next.rsp.prdata = {28'h0, state_reg.can_bit_rate};
        A_LABEL0: state_next.rsp.prdata = state_reg.axis_label[31:0];
        A_LABEL1: state_next.rsp.prdata = state_reg.axis_label[63:32];
        A_AUTOEN: state_next.rsp.prdata = {31'h0,
          state_reg.auto_software_enable};
        A_WDTO: state_next.rsp.prdata = {state_reg.wd_count,
          state_reg.comm_watchdog_timeout};
        A_UNITS: state_next.rsp.prdata = {12'h0, state_reg.position_unit,
          4'h0, state_reg.velocity_unit_select, 4'h0,
          state_reg.accel_unit_select};
        A_RUNTIME: state_next.rsp.prdata = state_reg.saved_time;
        A_HWVER: state_next.rsp.prdata = HW_VERSION;
        A_FWVER: state_next.rsp.prdata = FW_VERSION;
        A_SERIAL: state_next.rsp.prdata = SERIAL_NUM;
        A_KICK: state_next.rsp.prdata = 32'h0000_0000;
        default: state_next.rsp.pslverr = 1'b1;
      endcase
    end
    // hardware retrigger wins over a same-cycle kick; warning set sticks
    if (bus_retrigger) begin
      state_next.wd_count = state_reg.comm_watchdog_timeout;
    end

    // reset clears errors, then auto enable picks the start state
    if (rst_seen_reg) begin
      state_next.sw_enable = state_reg.auto_software_enable &&
        enable_mode;
    end

    // fieldbus id: zero means unset
    state_next.bus_node_id = (state_reg.bus_addr != 6'h00) ?
      state_reg.bus_addr : state_reg.station_addr;

    // phase loss handling
    state_next.drive.phase_warn = phase_missing &&
      (state_reg.phase_loss_handling == PHASE_WARN);
    state_next.drive.phase_fault = phase_missing &&
      (state_reg.phase_loss_handling == PHASE_FAULT);
    state_next.drive.drive_disable = state_next.drive.phase_fault;
    state_next.drive.rto_closed = !state_next.drive.phase_fault;
    // cap applies in codes 0 and 1 while a phase is gone
    state_next.drive.peak_cap_on = phase_missing &&
      (state_reg.phase_loss_handling != PHASE_FAULT);
    state_next.drive.drive_stop = state_reg.response_timeout_warning;
    state_next.drive.setpoint_block = state_reg.response_timeout_warning;
    state_next.drive.sw_enable = state_reg.sw_enable;

    state_next.setpoint_accept = setpoint_valid &&
      !state_reg.response_timeout_warning;
    if (state_next.setpoint_accept) begin
      state_next.setpoint_out = setpoint_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.phase_loss_handling <= PHASE_RST;
      state_reg.station_addr <= ADDR_RST;
      state_reg.bus_addr <= ADDR_RST;
      state_reg.can_bit_rate <= CANBR_RST;
      state_reg.axis_label <= {LABEL_RST, LABEL_RST};
      state_reg.auto_software_enable <= AUTOEN_RST;
      state_reg.comm_watchdog_timeout <= WDTO_RST;
      state_reg.wd_count <= WDTO_RST;
      state_reg.drive.rto_closed <= 1'b1;
    end else begin
      state_reg <= state_next;
      // reset clears errors, so enable only reloads on reset release
    end
  end

  // marks the first edge after reset release for the enable reload
  always_ff @(posedge core_clk) begin
    rst_seen_reg <= rst;
  end

  assign apb_rsp = state_reg.rsp;
  assign drive = state_reg.drive;
  assign bus_node_id = state_reg.bus_node_id;
  assign can_bit_rate = state_reg.can_bit_rate;
  assign accel_unit_select = state_reg.accel_unit_select;
  assign velocity_unit_select = state_reg.velocity_unit_select;
  assign position_unit = state_reg.position_unit;
  assign accel_convert_req = state_reg.accel_convert_req;
  assign nv_commit = state_reg.nv_commit;
  assign operating_time = state_reg.saved_time;
  assign setpoint_accept = state_reg.setpoint_accept;
  assign setpoint_out = state_reg.setpoint_out;
endmodule

// ### core/dss_pkg.sv
// Purpose: constants and carriers for the drive setup supervision block
// Assumes: 10 MHz core clock, 32-bit APB
// Notes: byte offsets of the APB register map
package dss_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MS_PER_SEC = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_SEC;
  localparam int unsigned SAVE_MIN = 8;
  localparam int unsigned SAVE_MS = SAVE_MIN * 60 * MS_PER_SEC;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_PHASE = 12'h008;
  localparam logic [11:0] A_ADDR = 12'h00C;
  localparam logic [11:0] A_CANBR = 12'h010;
  localparam logic [11:0] A_LABEL0 = 12'h014;
  localparam logic [11:0] A_LABEL1 = 12'h018;
  localparam logic [11:0] A_AUTOEN = 12'h01C;
  localparam logic [11:0] A_WDTO = 12'h020;
  localparam logic [11:0] A_UNITS = 12'h024;
  localparam logic [11:0] A_RUNTIME = 12'h028;
  localparam logic [11:0] A_HWVER = 12'h02C;
  localparam logic [11:0] A_FWVER = 12'h030;
  localparam logic [11:0] A_SERIAL = 12'h034;
  localparam logic [11:0] A_KICK = 12'h038;
  localparam logic [1:0] PHASE_RST = 2'h1;
  localparam logic [1:0] PHASE_IGNORE = 2'h0;
  localparam logic [1:0] PHASE_WARN = 2'h1;
  localparam logic [1:0] PHASE_FAULT = 2'h2;
  localparam logic [5:0] ADDR_RST = 6'h00;
  localparam logic [3:0] CANBR_RST = 4'h7;
  localparam logic [3:0] CANBR_MAX = 4'hA;
  localparam logic [31:0] LABEL_RST = 32'h2020_2020;
  localparam logic AUTOEN_RST = 1'b1;
  localparam logic [15:0] WDTO_RST = 16'h0064;
  localparam logic [3:0] ACC_MAX = 4'h5;
  localparam logic [3:0] VEL_MAX = 4'h8;
  localparam logic [3:0] POS_MAX = 4'h9;
  localparam logic [15:0] PEAK_LIMIT_4A = 16'h0FA0;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dss_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dss_apb_rsp_t;
  typedef struct packed {
    logic phase_warn;
    logic phase_fault;
    logic rto_closed;
    logic drive_disable;
    logic drive_stop;
    logic setpoint_block;
    logic peak_cap_on;
    logic sw_enable;
  } dss_drive_t;
endpackage

// ### tb/dss_chk.sv
// Purpose: port assertions for the setup supervision block
// Assumes: one clock, synchronous high reset
// Notes: bound to every dss_top instance
module dss_chk
  import dss_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire dss_pkg::dss_apb_req_t apb_req,
  input wire dss_pkg::dss_apb_rsp_t apb_rsp,
  input wire logic setpoint_valid,
  input wire logic setpoint_accept,
  input wire dss_pkg::dss_drive_t drive,
  input wire logic [3:0] can_bit_rate,
  input wire logic [3:0] accel_unit_select,
  input wire logic [3:0] velocity_unit_select,
  input wire logic [3:0] position_unit,
  input wire logic nv_commit
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ans_next_a: assert property (apb_req.psel && apb_req.penable
    && !apb_rsp.pready |=> apb_rsp.pready) else $error("late pready");
  rdy_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready too long");
  fault_opens_a: assert property (
    drive.phase_fault |-> !drive.rto_closed && drive.drive_disable)
    else $error("fault keeps contact");
  warn_enabled_a: assert property (
    drive.phase_warn |-> !drive.drive_disable && drive.peak_cap_on)
    else $error("warning disables drive");
  stop_enabled_a: assert property (
    drive.drive_stop && !drive.phase_fault |-> !drive.drive_disable)
    else $error("stop disables drive");
  block_reject_a: assert property (
    drive.setpoint_block && setpoint_valid |=> !setpoint_accept)
    else $error("setpoint taken while blocked");
  accept_cause_a: assert property (
    setpoint_accept |-> $past(setpoint_valid))
    else $error("accept without setpoint");
  units_range_a: assert property (
    accel_unit_select <= ACC_MAX && velocity_unit_select <= VEL_MAX
    && position_unit <= POS_MAX) else $error("unit out of range");
  can_range_a: assert property (can_bit_rate <= CANBR_MAX)
    else $error("bit rate out of range");
  commit_pulse_a: assert property (nv_commit |=> !nv_commit)
    else $error("commit pulse too long");
endmodule

bind dss_top dss_chk u_chk (
  .core_clk(core_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .setpoint_valid(setpoint_valid), .setpoint_accept(setpoint_accept),
  .drive(drive), .can_bit_rate(can_bit_rate),
  .accel_unit_select(accel_unit_select),
  .velocity_unit_select(velocity_unit_select),
  .position_unit(position_unit), .nv_commit(nv_commit)
);

// ### tb/dss_host.sv
// Purpose: setup host writing and reading parameters over apb
// Assumes: slave answers within a few cycles
// Notes: request held until pready seen at a rising edge
module dss_host
  import dss_pkg::*;
(
  input wire logic core_clk,
  input wire dss_pkg::dss_apb_rsp_t apb_rsp,
  output dss_pkg::dss_apb_req_t apb_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial apb_req = '0;
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    // released bus shows no stale write data
    apb_req <= '{1'b0, 1'b0, 1'b0, 12'h000, ~d};
  endtask
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench of the setup supervision block
// Assumes: short save period and tick for a quick run
// Notes: host model makes every register access
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dss_pkg::*;
  localparam logic [31:0] HWV = 32'h0000_0042; // arbitrary
  logic core_clk, rst = 1, phase_missing = 0, output_stage_enabled = 0;
  logic bus_retrigger = 0, setpoint_valid = 0, accel_convert_done = 0;
  logic [31:0] setpoint_in = '0, setpoint_out, operating_time, q, t0;
  logic setpoint_accept, accel_convert_req, nv_commit, e;
  logic [3:0] can_bit_rate, acc, vel, pos;
  logic [5:0] bus_node_id;
  logic [3:0] opfn = 4'h0;
  dss_apb_req_t apb_req;
  dss_apb_rsp_t apb_rsp;
  dss_drive_t drive;
  int err_total = 0, checks = 0, cyc = 0;
  dss_top #(.SAVE_PERIOD_MS(3), .TICK_CYCLES(4), .HW_VERSION(HWV)) u_dss_top (
    .core_clk(core_clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .phase_missing(phase_missing), .operating_function(opfn),
    .output_stage_enabled(output_stage_enabled),
    .bus_retrigger(bus_retrigger), .setpoint_valid(setpoint_valid),
    .setpoint_in(setpoint_in), .accel_convert_done(accel_convert_done),
    .setpoint_accept(setpoint_accept), .setpoint_out(setpoint_out),
    .drive(drive), .bus_node_id(bus_node_id), .can_bit_rate(can_bit_rate),
    .accel_unit_select(acc), .velocity_unit_select(vel),
    .position_unit(pos), .accel_convert_req(accel_convert_req),
    .nv_commit(nv_commit), .operating_time(operating_time));
  dss_host u_dss_host (.core_clk(core_clk), .apb_rsp(apb_rsp),
    .apb_req(apb_req));
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task chk(input string name, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_dss_host.xfer(1'b1, a, d, q, e);
  endtask
  task rd(input logic [11:0] a);
    u_dss_host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  task settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task do_reset;
    rst <= 1;
    repeat (2) @(posedge core_clk);
    rst <= 0;
  endtask
  task send_sp(input logic exp);
    @(posedge core_clk);
    setpoint_valid <= 1;
    setpoint_in <= 32'hA5A5_0001;
    @(posedge core_clk);
    setpoint_valid <= 0;
    #1;
    chk("accept", setpoint_accept, exp);
  endtask
  task t_defaults;
    rd(A_PHASE); chk("phase", q[1:0], PHASE_RST);
    rd(A_CANBR); chk("canbr", q[3:0], CANBR_RST);
    rd(A_LABEL0); chk("label0", q, LABEL_RST);
    rd(A_LABEL1); chk("label1", q, LABEL_RST);
    rd(A_AUTOEN); chk("autoen", q[0], 1'b1);
    rd(A_WDTO); chk("wdto", q[15:0], WDTO_RST);
    rd(A_UNITS); chk("units", q[19:0], 20'h0_0000);
    rd(A_ADDR); chk("addr", q[13:0], 14'h0000);
    rd(A_CTRL); chk("sw en", q[0], 1'b1);
    chk("drive en", drive.sw_enable, 1'b1);
  endtask
  task t_phase;
    for (int c = 0; c < 3; c++) begin
      wr(A_PHASE, 32'(c)); // output stage held disabled
      phase_missing <= 1;
      settle;
      chk("warn", drive.phase_warn, c == 1);
      chk("fault", drive.phase_fault, c == 2);
      chk("rto", drive.rto_closed, c != 2);
      chk("disable", drive.drive_disable, c == 2);
      chk("peak", drive.peak_cap_on, c != 2);
      phase_missing <= 0;
    end
    wr(A_PHASE, 32'h0000_0003); chk("phase3", e, 1'b1);
    rd(A_PHASE); chk("phase kept", q[1:0], 2'h2);
    do_reset;
  endtask
  task t_addr;
    wr(A_ADDR, 32'h0000_0005); settle;
    chk("station", bus_node_id, 6'h05);
    wr(A_ADDR, 32'h0000_3F05); settle;
    chk("fieldbus", bus_node_id, 6'h3F);
    rd(A_ADDR); chk("node rd", q[21:16], 6'h3F);
  endtask
  task t_can;
    for (int i = 0; i < 12; i++) begin
      wr(A_CANBR, 32'(i)); chk("can err", e, i > 10);
    end
    settle; chk("can", can_bit_rate, 4'hA);
  endtask
  task t_units;
    wr(A_UNITS, 32'h0009_0805); chk("units ok", e, 1'b0);
    settle; chk("units", {acc, vel, pos}, 12'h589);
    chk("conv req", accel_convert_req, 1'b1);
    accel_convert_done <= 1;
    @(posedge core_clk);
    accel_convert_done <= 0;
    settle; chk("conv end", accel_convert_req, 1'b0);
    wr(A_UNITS, 32'h0009_0806); chk("acc6", e, 1'b1);
    wr(A_UNITS, 32'h0009_0905); chk("vel9", e, 1'b1);
    wr(A_UNITS, 32'h000A_0805); chk("pos10", e, 1'b1);
    rd(A_UNITS); chk("units kept", q[19:0], 20'h9_0805);
  endtask
  task t_misc;
    wr(A_LABEL1, 32'h4443_4241);
    rd(A_LABEL1); chk("label", q, 32'h4443_4241);
    wr(A_HWVER, 32'h0000_0000); chk("hw ro", e, 1'b1);
    rd(A_HWVER); chk("hw", q, HWV);
    rd(A_FWVER); chk("fw", q, 32'h0000_0001);
    wr(A_SERIAL, 32'h0000_0000); chk("ser ro", e, 1'b1);
    wr(12'h03C, 32'h0000_0000); chk("unmapped", e, 1'b1);
  endtask
  task t_wd;
    wr(A_WDTO, 32'h0000_0002);
    repeat (30) @(posedge core_clk);
    #1; chk("idle wd", drive.drive_stop, 1'b0);
    output_stage_enabled <= 1;
    wr(A_KICK, 32'h0000_0001);
    repeat (8) begin
      @(posedge core_clk);
      bus_retrigger <= 1;
      @(posedge core_clk);
      bus_retrigger <= 0;
      repeat (2) @(posedge core_clk);
    end
    #1; chk("fed", drive.drive_stop, 1'b0);
    send_sp(1'b1);
    repeat (30) @(posedge core_clk);
    #1; chk("stop", drive.drive_stop, 1'b1);
    chk("block", drive.setpoint_block, 1'b1);
    chk("enabled", drive.drive_disable, 1'b0);
    send_sp(1'b0);
    output_stage_enabled <= 0;
    do_reset;
    settle; chk("cleared", drive.drive_stop, 1'b0);
    send_sp(1'b1);
    opfn <= 4'h1;
    do_reset;
    settle; chk("mode1 en", drive.sw_enable, 1'b0);
    opfn <= 4'h0;
  endtask
  task t_time;
    int n;
    n = 0;
    while (nv_commit !== 1'b1 && n < 40) begin
      @(posedge core_clk); #1; n++;
    end
    settle;
    t0 = operating_time;
    n = 2;
    do begin
      @(posedge core_clk); #1; n++;
    end while (nv_commit !== 1'b1 && n < 40);
    chk("save gap", n, 12);
    settle; chk("runtime", operating_time, t0 + 1);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    do_reset;
    t_defaults; t_phase; t_addr; t_can; t_units; t_misc; t_wd; t_time;
    close_out;
  end
endmodule
